// ==== pkg/gpw_pkg.sv ====
// Constants shared by the pin, wake and external interrupt logic.
// Assumes a 100 MHz system clock and 24 pins as three ports of eight.
package gpw_pkg;
    localparam int NUM_PINS = 24;
    localparam int CFG_W = 4;
    // Pin configuration codes
    localparam logic [3:0] CFG_ANALOG = 4'h0;
    localparam logic [3:0] CFG_OUT_PP = 4'h1;
    localparam logic [3:0] CFG_IN_FLOAT = 4'h4;
    localparam logic [3:0] CFG_OUT_OD = 4'h5;
    localparam logic [3:0] CFG_IN_PULL = 4'h8;
    localparam logic [3:0] CFG_ALT_PP = 4'h9;
    localparam logic [3:0] CFG_ALT_SCLK = 4'hB;
    localparam logic [3:0] CFG_ALT_OD = 4'hD;
    localparam logic [3:0] CFG_RESET = 4'h4;
    // Trigger modes
    localparam logic [2:0] TRIG_OFF = 3'h0;
    localparam logic [2:0] TRIG_RISE = 3'h1;
    localparam logic [2:0] TRIG_FALL = 3'h2;
    localparam logic [2:0] TRIG_BOTH = 3'h3;
    localparam logic [2:0] TRIG_HIGH = 3'h4;
    localparam logic [2:0] TRIG_LOW = 3'h5;
    // Fixed pins of channels A and B (PB0, PB6)
    localparam logic [4:0] IRQ_A_PIN = 5'h08;
    localparam logic [4:0] IRQ_B_PIN = 5'h0E;
    // Pulse widths and cycle counts
    localparam int CLK_PERIOD_NS = 10;
    localparam int UNFILT_MIN_NS = 80;
    localparam int FILT_MIN_NS = 450;
    localparam int FILT_CYCLES = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 3;
    localparam int WAKE_SAMPLES = 3;
    localparam int NUM_WAKE_SRC = 4;
endpackage

// ==== core/gpw_core.sv ====
// Pin mode logic, output set/clear latch, deep sleep wake monitor and
// four external interrupt channels with write-one-to-clear flags.
// Assumes pins and the slow oscillator tick come from outside sys_clk.
`timescale 1ns/100ps
module gpw_core
    import gpw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pins (output enable low while driving)
    input wire logic [gpw_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpw_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpw_pkg::NUM_PINS-1:0] pin_oe_n,
    output logic [gpw_pkg::NUM_PINS-1:0] pull_up_en,
    output logic [gpw_pkg::NUM_PINS-1:0] pull_down_en,
    // Peripheral side
    input wire logic [gpw_pkg::NUM_PINS-1:0] alt_out,
    output logic [gpw_pkg::NUM_PINS-1:0] periph_in,
    // Configuration
    output logic [gpw_pkg::NUM_PINS*gpw_pkg::CFG_W-1:0] pin_config_reg,
    input wire logic cfg_we,
    input wire logic [gpw_pkg::NUM_PINS*gpw_pkg::CFG_W-1:0] cfg_wdata,
    // Output latch access
    input wire logic out_we,
    input wire logic [gpw_pkg::NUM_PINS-1:0] out_wdata,
    input wire logic set_we,
    input wire logic [gpw_pkg::NUM_PINS-1:0] output_set_reg,
    input wire logic clr_we,
    input wire logic [gpw_pkg::NUM_PINS-1:0] output_clear_reg,
    output logic [gpw_pkg::NUM_PINS-1:0] output_latch_reg,
    output logic [gpw_pkg::NUM_PINS-1:0] pin_input_reg,
    // Wake monitor
    input wire logic sleep_entry,
    input wire logic slow_tick,
    input wire logic pin_wake_sel,
    input wire logic [gpw_pkg::NUM_PINS-1:0] wake_enable_reg,
    input wire logic [gpw_pkg::NUM_WAKE_SRC-1:0] wake_filter_ctl,
    input wire logic serial_one_act,
    input wire logic serial_two_act,
    output logic [gpw_pkg::NUM_WAKE_SRC-1:0] wake_event,
    output logic pin_wake_flag,
    // External interrupts
    input wire logic [11:0] irq_trigger_mode,
    input wire logic [3:0] irq_filter_enable,
    input wire logic [4:0] irq_c_pin_select,
    input wire logic [4:0] irq_d_pin_select,
    input wire logic flag_we,
    input wire logic [3:0] flag_wdata,
    output logic [3:0] ext_irq_flag_reg,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic ext_irq_c,
    output logic ext_irq_d,
    // Debug status
    input wire logic debug_forced_flag,
    input wire logic serial_wire_active_flag,
    input wire logic boot_select_pin,
    output logic [2:0] debug_status_reg
);
    import gpw_pkg::*;

    // ********************************************************
    // Helper functions
    // ********************************************************
    function automatic logic [3:0] cfg_of(input logic [NUM_PINS*CFG_W-1:0] v,
                                          input int i);
        cfg_of = v[i*CFG_W +: CFG_W];
    endfunction

    function automatic logic is_input_mode(input logic [3:0] c);
        is_input_mode = (c == CFG_IN_FLOAT) || (c == CFG_IN_PULL);
    endfunction

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    logic [NUM_PINS-1:0] sync1, sync2, next_sync1, next_sync2;
    logic [1:0] ser1, ser2, next_ser1, next_ser2;
    logic [1:0] tick_s, next_tick_s;
    logic tick_d, next_tick_d;

    // Two stages before anything looks at a pin
    always_comb begin
        next_sync1 = pin_in;
        next_sync2 = sync1;
        next_ser1 = {ser1[0], serial_one_act};
        next_ser2 = {ser2[0], serial_two_act};
        next_tick_s = {tick_s[0], slow_tick};
        next_tick_d = tick_s[1];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
            ser1 <= 2'h0;
            ser2 <= 2'h0;
            tick_s <= 2'h0;
            tick_d <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            ser1 <= next_ser1;
            ser2 <= next_ser2;
            tick_s <= next_tick_s;
            tick_d <= next_tick_d;
        end
    end

    // Slow oscillator sample strobe, taken only after synchronising
    logic slow_edge;
    assign slow_edge = tick_s[1] & ~tick_d;

    // ********************************************************
    // Configuration and output latch
    // ********************************************************
    logic [NUM_PINS*CFG_W-1:0] cfg, next_cfg;
    logic [NUM_PINS-1:0] next_latch;

    // Clear acts after set so both in one cycle leave the bit clear
    always_comb begin
        next_cfg = cfg_we ? cfg_wdata : cfg;
        next_latch = out_we ? out_wdata : output_latch_reg;
        if (set_we) begin
            next_latch = next_latch | output_set_reg;
        end
        if (clr_we) begin
            next_latch = next_latch & ~output_clear_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg <= {NUM_PINS{CFG_RESET}};
            output_latch_reg <= '0;
        end else begin
            cfg <= next_cfg;
            output_latch_reg <= next_latch;
        end
    end

    // Readback port shows the stored codes straight from the flops
    logic [NUM_PINS*CFG_W-1:0] cfg_view;
    assign cfg_view = cfg;
    assign pin_config_reg = cfg;

    // ********************************************************
    // Per-pin driver, pulls and input path
    // ********************************************************
    logic [NUM_PINS-1:0] dig_in;
    logic [NUM_PINS-1:0] next_pin_out, next_oe_n, next_pu, next_pd;

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        logic [3:0] c;
        logic drv;
        assign c = cfg_of(cfg_view, g);
        // Analog forces a constant one into the digital path
        assign dig_in[g] = (c == CFG_ANALOG) ? 1'b1 : sync2[g];
        always_comb begin
            drv = output_latch_reg[g];
            if (c == CFG_ALT_PP || c == CFG_ALT_SCLK || c == CFG_ALT_OD) begin
                drv = alt_out[g];
            end
            next_pin_out[g] = 1'b0;
            next_oe_n[g] = 1'b1;
            next_pu[g] = 1'b0;
            next_pd[g] = 1'b0;
            case (c)
                CFG_OUT_PP, CFG_ALT_PP, CFG_ALT_SCLK: begin
                    next_pin_out[g] = drv;
                    next_oe_n[g] = 1'b0;
                end
                CFG_OUT_OD, CFG_ALT_OD: begin
                    next_pin_out[g] = 1'b0;
                    next_oe_n[g] = drv;
                end
                CFG_IN_PULL: begin
                    next_pu[g] = output_latch_reg[g];
                    next_pd[g] = ~output_latch_reg[g];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pull_up_en <= '0;
            pull_down_en <= '0;
            pin_input_reg <= '1;
            periph_in <= '1;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_oe_n;
            pull_up_en <= next_pu;
            pull_down_en <= next_pd;
            pin_input_reg <= dig_in;
            periph_in <= dig_in;
        end
    end

    // ********************************************************
    // Wake monitor
    // ********************************************************
    logic [NUM_PINS-1:0] snap, next_snap;
    logic asleep, next_asleep;
    logic next_pin_wake_flag;
    logic [NUM_WAKE_SRC-1:0] src_now, src_snap, next_src_snap, raw_chg;
    logic [NUM_WAKE_SRC-1:0] next_wake;
    logic [1:0] hist [NUM_WAKE_SRC];
    logic [1:0] next_hist [NUM_WAKE_SRC];
    logic pin_chg;
    logic pin_lvl;

    // Any enabled non-analog pin differing from its snapshot
    always_comb begin
        pin_chg = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (wake_enable_reg[i] && cfg_of(cfg_view, i) != CFG_ANALOG &&
                dig_in[i] != snap[i]) begin
                pin_chg = 1'b1;
            end
        end
    end

    // Channel D pin level; a select beyond the last pin reads as zero
    function automatic logic ext_irq_d_lvl();
        ext_irq_d_lvl = (irq_d_pin_select < 5'h18) ? dig_in[irq_d_pin_select] : 1'b0;
    endfunction

    // Pin source as a single level: high while any enabled pin has moved
    assign pin_lvl = pin_chg;
    assign src_now = {ext_irq_d_lvl(), ser2[1], ser1[1], pin_lvl};

    always_comb begin
        next_asleep = asleep;
        next_snap = snap;
        next_src_snap = src_snap;
        next_wake = '0;
        next_pin_wake_flag = pin_wake_flag;
        if (sleep_entry) begin
            next_asleep = 1'b1;
            next_snap = dig_in;
            next_src_snap = {ext_irq_d_lvl(), ser2[1], ser1[1], 1'b0};
            next_pin_wake_flag = 1'b0;
        end
        for (int s = 0; s < NUM_WAKE_SRC; s++) begin
            raw_chg[s] = src_now[s] != src_snap[s];
            next_hist[s] = slow_edge ? {hist[s][0], src_now[s]} : hist[s];
            if (asleep && !sleep_entry) begin
                if (!wake_filter_ctl[s]) begin
                    next_wake[s] = raw_chg[s];
                end else if (slow_edge && hist[s] == {2{src_now[s]}} && raw_chg[s]) begin
                    next_wake[s] = 1'b1;
                end
            end
        end
        next_wake[0] = next_wake[0] & pin_wake_sel;
        if (next_wake[0]) begin
            next_pin_wake_flag = 1'b1;
        end
        if (|next_wake) begin
            next_asleep = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            asleep <= 1'b0;
            snap <= '0;
            src_snap <= '0;
            wake_event <= '0;
            pin_wake_flag <= 1'b0;
            for (int s = 0; s < NUM_WAKE_SRC; s++) begin
                hist[s] <= 2'h0;
            end
        end else begin
            asleep <= next_asleep;
            snap <= next_snap;
            src_snap <= next_src_snap;
            wake_event <= next_wake;
            pin_wake_flag <= next_pin_wake_flag;
            for (int s = 0; s < NUM_WAKE_SRC; s++) begin
                hist[s] <= next_hist[s];
            end
        end
    end

    // ********************************************************
    // External interrupt channels
    // ********************************************************
    logic [3:0] ch_raw, ch_filt, ch_prev, next_ch_filt, next_ch_prev, hit;
    logic [3:0] next_flag;
    logic [5:0] fcnt [4];
    logic [5:0] next_fcnt [4];
    logic [4:0] ch_pin [4];

    // Normal input path feeds every channel
    assign ch_pin[0] = IRQ_A_PIN;
    assign ch_pin[1] = IRQ_B_PIN;
    assign ch_pin[2] = irq_c_pin_select;
    assign ch_pin[3] = irq_d_pin_select;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ch_raw[k] = (ch_pin[k] < 5'h18) ? dig_in[ch_pin[k]] : 1'b0;
            // Filter holds until the level stands FILT_CYCLES
            next_fcnt[k] = 6'h00;
            next_ch_filt[k] = ch_filt[k];
            if (!irq_filter_enable[k]) begin
                next_ch_filt[k] = ch_raw[k];
            end else if (ch_raw[k] != ch_filt[k]) begin
                next_fcnt[k] = fcnt[k] + 6'h01;
                if (fcnt[k] == 6'(FILT_CYCLES - 1)) begin
                    next_ch_filt[k] = ch_raw[k];
                    next_fcnt[k] = 6'h00;
                end
            end
            next_ch_prev[k] = ch_filt[k];
            case (irq_trigger_mode[k*3 +: 3])
                TRIG_RISE: hit[k] = ch_filt[k] & ~ch_prev[k];
                TRIG_FALL: hit[k] = ~ch_filt[k] & ch_prev[k];
                TRIG_BOTH: hit[k] = ch_filt[k] ^ ch_prev[k];
                TRIG_HIGH: hit[k] = ch_filt[k];
                TRIG_LOW: hit[k] = ~ch_filt[k];
                default: hit[k] = 1'b0;
            endcase
        end
        // Set wins over a same-cycle clear
        next_flag = ext_irq_flag_reg;
        if (flag_we) begin
            next_flag = next_flag & ~flag_wdata;
        end
        next_flag = next_flag | hit;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ch_filt <= 4'h0;
            ch_prev <= 4'h0;
            ext_irq_flag_reg <= 4'h0;
            for (int k = 0; k < 4; k++) begin
                fcnt[k] <= 6'h00;
            end
        end else begin
            ch_filt <= next_ch_filt;
            ch_prev <= next_ch_prev;
            ext_irq_flag_reg <= next_flag;
            for (int k = 0; k < 4; k++) begin
                fcnt[k] <= next_fcnt[k];
            end
        end
    end

    assign ext_irq_a = ext_irq_flag_reg[0];
    assign ext_irq_b = ext_irq_flag_reg[1];
    assign ext_irq_c = ext_irq_flag_reg[2];
    assign ext_irq_d = ext_irq_flag_reg[3];

    // ********************************************************
    // Debug status: boot pin caught after reset release
    // ********************************************************
    logic boot_seen, next_boot_seen, boot_flag, next_boot_flag;
    logic [1:0] boot_s, next_boot_s;
    logic [2:0] next_dbg;

    // Boot pin synchroniser runs through reset so its level is valid at release
    always_comb begin
        next_boot_s = {boot_s[0], boot_select_pin};
        next_boot_seen = 1'b1;
        next_boot_flag = boot_seen ? boot_flag : !boot_s[1];
        next_dbg = {boot_flag, serial_wire_active_flag, debug_forced_flag};
    end

    always_ff @(posedge sys_clk) begin
        boot_s <= next_boot_s;
        if (!reset_n) begin
            boot_seen <= 1'b0;
            boot_flag <= 1'b0;
            debug_status_reg <= 3'h0;
        end else begin
            boot_seen <= next_boot_seen;
            boot_flag <= next_boot_flag;
            debug_status_reg <= next_dbg;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    sequence s_flag_clear(int k);
        flag_we && flag_wdata[k] && !hit[k];
    endsequence

    a_analog_reads_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cfg_of(cfg_view, 3) == CFG_ANALOG |=> pin_input_reg[3])
        else $error("analog pin did not read one");
    a_input_no_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_input_mode(cfg_of(cfg_view, 1)) |=> pin_oe_n[1])
        else $error("input pin driven");
    a_pull_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cfg_of(cfg_view, 2) == CFG_IN_PULL |=> pull_up_en[2] == $past(output_latch_reg[2]))
        else $error("pull direction wrong");
    a_od_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cfg_of(cfg_view, 1) == CFG_OUT_OD |=> pin_oe_n[1] == $past(output_latch_reg[1]))
        else $error("open drain drive wrong");
    a_set_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        set_we && !clr_we && !out_we |=> (output_latch_reg & $past(output_set_reg))
        == $past(output_set_reg))
        else $error("set bits not set");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_flag_clear(0) |=> !ext_irq_flag_reg[0])
        else $error("flag not cleared");
    a_level_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        irq_trigger_mode[2:0] == TRIG_HIGH && ch_filt[0] |=> ext_irq_flag_reg[0])
        else $error("level flag not held");
    a_pin_wake_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !pin_wake_sel |=> !wake_event[0])
        else $error("pin wake without select");
endmodule

// ==== dv/gpw_pad_model.sv ====
// Far-side pad model: resolves each pad from the device, an outside driver and pulls.
// Assumes the bench changes ext_en and ext_val away from the rising edge.
`timescale 1ns/100ps
module gpw_pad_model
    import gpw_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Device pad controls
    input wire logic [gpw_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gpw_pkg::NUM_PINS-1:0] pin_oe_n,
    input wire logic [gpw_pkg::NUM_PINS-1:0] pull_up_en,
    input wire logic [gpw_pkg::NUM_PINS-1:0] pull_down_en,
    // Outside drivers
    input wire logic [gpw_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [gpw_pkg::NUM_PINS-1:0] ext_val,
    // Pad levels
    output logic [gpw_pkg::NUM_PINS-1:0] pin_in
);
    logic wander = 1'h0;
    // A bare pad wanders, so a stale level never passes for a real one
    always @(posedge sys_clk) begin
        wander <= ~wander;
    end
    // Device driver first, then the outside driver, then the weak pulls
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pull_up_en[i] || pull_down_en[i]) begin
                pin_in[i] = pull_up_en[i];
            end else begin
                pin_in[i] = wander;
            end
        end
    end
endmodule

// ==== dv/gpw_core_bench.sv ====
// Self-checking bench for gpw_core: modes, latch, wake monitor, interrupts.
// Assumes gpw_pad_model resolves the pads; inputs change at falling edges.
`timescale 1ns/100ps
module gpw_core_bench;
    import gpw_pkg::*;
    // ****************
    // Signals
    // ****************
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    logic slow_tick = 1'h0;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en, periph_in;
    logic [NUM_PINS-1:0] output_latch_reg, pin_input_reg;
    logic [NUM_PINS-1:0] alt_out = '0, out_wdata = '0, output_set_reg = '0;
    logic [NUM_PINS-1:0] output_clear_reg = '0, wake_enable_reg = '0, ext_val = '0;
    logic [NUM_PINS-1:0] ext_en = 24'h084548;
    logic [95:0] pin_config_reg, cfg_wdata = '0;
    logic cfg_we = 1'h0, out_we = 1'h0, set_we = 1'h0, clr_we = 1'h0, flag_we = 1'h0;
    logic sleep_entry = 1'h0, pin_wake_sel = 1'h0, serial_one_act = 1'h0;
    logic serial_two_act = 1'h0, debug_forced_flag = 1'h0, serial_wire_active_flag = 1'h1;
    logic boot_select_pin = 1'h0, pin_wake_flag, ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d;
    logic [3:0] wake_filter_ctl = 4'h0, irq_filter_enable = 4'h0, flag_wdata = 4'h0;
    logic [3:0] wake_event, ext_irq_flag_reg;
    logic [11:0] irq_trigger_mode = 12'h000;
    logic [4:0] irq_c_pin_select = 5'h00, irq_d_pin_select = 5'h00;
    logic [2:0] debug_status_reg;
    int n_errors = 0, num_checks = 0, cycles = 0;

    gpw_core u_gpw_core (.sys_clk, .reset_n, .pin_in, .pin_out, .pin_oe_n, .pull_up_en,
        .pull_down_en, .alt_out, .periph_in, .pin_config_reg, .cfg_we, .cfg_wdata, .out_we,
        .out_wdata, .set_we, .output_set_reg, .clr_we, .output_clear_reg, .output_latch_reg,
        .pin_input_reg, .sleep_entry, .slow_tick, .pin_wake_sel, .wake_enable_reg,
        .wake_filter_ctl, .serial_one_act, .serial_two_act, .wake_event, .pin_wake_flag,
        .irq_trigger_mode, .irq_filter_enable, .irq_c_pin_select, .irq_d_pin_select, .flag_we,
        .flag_wdata, .ext_irq_flag_reg, .ext_irq_a, .ext_irq_b, .ext_irq_c, .ext_irq_d,
        .debug_forced_flag, .serial_wire_active_flag, .boot_select_pin, .debug_status_reg);
    gpw_pad_model u_gpw_pad_model (.sys_clk, .pin_out, .pin_oe_n, .pull_up_en, .pull_down_en,
        .ext_en, .ext_val, .pin_in);

    // Clocks: slow tick is twenty times slower and toggles on system clock falling edges
    always #5 sys_clk = ~sys_clk;
    always #100 slow_tick = ~slow_tick;
    // Cut a hung run short; the tests need well under this
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ****************
    // Helpers
    // ****************
    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Write strobes last one cycle; each starts on a fresh falling edge
    task automatic w_cfg(input logic [95:0] v);
        @(negedge sys_clk);
        cfg_wdata = v;
        cfg_we = 1'h1;
        @(negedge sys_clk);
        cfg_we = 1'h0;
    endtask
    task automatic w_out(input logic [NUM_PINS-1:0] v);
        @(negedge sys_clk);
        out_wdata = v;
        out_we = 1'h1;
        @(negedge sys_clk);
        out_we = 1'h0;
    endtask
    task automatic w_flag(input logic [3:0] v);
        @(negedge sys_clk);
        flag_wdata = v;
        flag_we = 1'h1;
        @(negedge sys_clk);
        flag_we = 1'h0;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        tick(3);
        check("latch_rst", output_latch_reg, 24'h000000);
        check("oe_rst", pin_oe_n, 24'hFFFFFF);
        check("pull_rst", pull_up_en | pull_down_en, 24'h000000);
        check("flag_rst", ext_irq_flag_reg, 4'h0);
        check("dbg_boot", debug_status_reg, 3'h6);
        boot_select_pin = 1'h1;
        debug_forced_flag = 1'h1;
        tick(3);
        check("dbg_stat", debug_status_reg, 3'h7);
    endtask
    // Set and clear in one cycle, overlapping on bit 8: clear wins
    task automatic t_latch();
        w_out(24'hA5A5A5);
        check("latch_wr", output_latch_reg, 24'hA5A5A5);
        @(negedge sys_clk);
        output_set_reg = 24'h00010A;
        output_clear_reg = 24'h000105;
        set_we = 1'h1;
        clr_we = 1'h1;
        @(negedge sys_clk);
        set_we = 1'h0;
        clr_we = 1'h0;
        check("latch_sc", output_latch_reg, 24'hA5A4AA);
        @(negedge sys_clk);
        set_we = 1'h1;
        @(negedge sys_clk);
        set_we = 1'h0;
        check("latch_set", output_latch_reg, 24'hA5A5AA);
    endtask
    // Pins 0..7: PP, OD, pulled, analog, alt PP, alt clock, floating, alt OD
    task automatic t_modes(input logic v, input logic a);
        check("cfg_rd", pin_config_reg[31:0], 32'hD4B90851);
        @(negedge sys_clk);
        ext_val[6] = v;
        alt_out = {NUM_PINS{a}};
        w_out({16'h0000, {8{v}}});
        tick(5);
        check("oe_n", pin_oe_n[7:0], {a, 1'h1, 2'h0, 2'h3, v, 1'h0});
        check("pin_out", pin_out[7:0] & 8'hB3, {2'h0, a, a, 3'h0, v});
        check("pull_up", pull_up_en[7:0], {5'h00, v, 2'h0});
        check("pull_dn", pull_down_en[7:0], {5'h00, ~v, 2'h0});
        check("pin_in", pin_input_reg[7:0] & 8'h7D, {1'h0, v, a, a, 1'h1, v, 1'h0, v});
        check("periph", periph_in[7:0] & 8'h7D, {1'h0, v, a, a, 1'h1, v, 1'h0, v});
    endtask
    // Every trigger mode on channel A: rise, fall, zero write, one write
    task automatic t_irq_modes();
        logic [2:0] m;
        logic exp_r;
        for (int k = 0; k < 6; k++) begin
            m = k[2:0];
            exp_r = (m == TRIG_RISE) || (m == TRIG_BOTH) || (m >= TRIG_HIGH);
            @(negedge sys_clk);
            irq_trigger_mode = {9'h000, m};
            tick(6);
            w_flag(4'hF);
            tick(2);
            ext_val[8] = 1'h1;
            tick(6);
            check("irq_rise", ext_irq_flag_reg[0], exp_r);
            ext_val[8] = 1'h0;
            tick(6);
            check("irq_fall", ext_irq_a, m != TRIG_OFF);
            w_flag(4'h0);
            tick(2);
            check("w0_kept", ext_irq_flag_reg[0], m != TRIG_OFF);
            w_flag(4'h1);
            tick(3);
            check("w1_clear", ext_irq_flag_reg[0], m == TRIG_LOW);
        end
    endtask
    // Channel B on its fixed pin, C and D on selected pins of ports C and B
    task automatic t_irq_sel();
        int pins[3];
        pins = '{14, 19, 10};
        @(negedge sys_clk);
        irq_c_pin_select = 5'h13;
        irq_d_pin_select = 5'h0A;
        irq_trigger_mode = {TRIG_RISE, TRIG_RISE, TRIG_RISE, TRIG_OFF};
        for (int k = 0; k < 3; k++) begin
            tick(4);
            w_flag(4'hF);
            tick(2);
            ext_val[pins[k]] = 1'h1;
            tick(6);
            check("irq_sel", ext_irq_flag_reg, 32'h2 << k);
            check("irq_line", {ext_irq_d, ext_irq_c, ext_irq_b}, 32'h1 << k);
            ext_val[pins[k]] = 1'h0;
        end
    endtask
    task automatic t_filter(input int width, input logic filt, input logic exp);
        @(negedge sys_clk);
        irq_trigger_mode = {9'h000, TRIG_RISE};
        irq_filter_enable = {3'h0, filt};
        tick(50);
        w_flag(4'hF);
        tick(2);
        ext_val[8] = 1'h1;
        tick(width);
        ext_val[8] = 1'h0;
        tick(60);
        check("irq_filt", ext_irq_flag_reg[0], exp);
    endtask
    // Enter sleep, change or glitch one pin, then watch for the wake pulse
    task automatic t_wake(input logic filt, input logic sel, input int p, input logic glitch,
                          input logic exp);
        logic seen;
        seen = 1'h0;
        @(negedge sys_clk);
        wake_filter_ctl = {3'h0, filt};
        pin_wake_sel = sel;
        wake_enable_reg = 24'h000001 << p;
        tick(80);
        sleep_entry = 1'h1;
        tick(1);
        sleep_entry = 1'h0;
        tick(2);
        ext_val[p] = ~ext_val[p];
        if (glitch) begin
            tick(3);
            ext_val[p] = ~ext_val[p];
        end
        repeat (300) begin
            @(posedge sys_clk);
            #1;
            seen = seen | (wake_event[0] === 1'h1);
        end
        check("wake_event", seen, exp);
        check("wake_flag", pin_wake_flag, exp);
    endtask
    // Reset again mid-run with the boot pin high: flag drops, codes return
    task automatic t_reboot();
        @(negedge sys_clk);
        reset_n = 1'h0;
        tick(6);
        reset_n = 1'h1;
        tick(3);
        check("dbg_reboot", debug_status_reg, 3'h3);
        check("cfg_reboot", pin_config_reg[31:0], 32'h44444444);
    endtask
    // Main sequence
    initial begin
        tick(6);
        reset_n = 1'h1;
        t_reset();
        t_latch();
        w_cfg({{16{CFG_RESET}}, CFG_ALT_OD, CFG_IN_FLOAT, CFG_ALT_SCLK, CFG_ALT_PP,
               CFG_ANALOG, CFG_IN_PULL, CFG_OUT_OD, CFG_OUT_PP});
        t_modes(1'h1, 1'h0);
        t_modes(1'h0, 1'h1);
        t_irq_modes();
        t_irq_sel();
        t_filter(8, 1'h0, 1'h1);
        t_filter(30, 1'h1, 1'h0);
        t_filter(50, 1'h1, 1'h1);
        t_wake(1'h0, 1'h1, 6, 1'h0, 1'h1);
        t_wake(1'h0, 1'h0, 6, 1'h0, 1'h0);
        t_wake(1'h0, 1'h1, 3, 1'h0, 1'h0);
        t_wake(1'h1, 1'h1, 6, 1'h1, 1'h0);
        t_wake(1'h1, 1'h1, 6, 1'h0, 1'h1);
        t_reboot();
        report_and_stop();
    end
endmodule
